// ===== inc/motor_arbiter_pkg.sv
// Package for the motor command arbiter: register map, field layouts,
// reset values and shared types.
// Assumes a 32-bit Avalon-MM slave with word addressing in bytes.
package motor_arbiter_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ctrl_offset        = 8'h00;  // Sources, direction, local/remote
	localparam logic [7:0] panel_cmd_offset   = 8'h04;  // Panel key commands
	localparam logic [7:0] serial_cmd_offset  = 8'h08;  // Serial master commands
	localparam logic [7:0] set_sel_offset     = 8'h0c;  // Set, motor, unit selection
	localparam logic [7:0] set_op_offset      = 8'h10;  // Copy / reset set operation
	localparam logic [7:0] param_addr_offset  = 8'h14;  // Parameter index within set
	localparam logic [7:0] param_data_offset  = 8'h18;  // Parameter data window
	localparam logic [7:0] global_offset      = 8'h1c;  // Global settings word
	localparam logic [7:0] timer_offset       = 8'h20;  // Shared timer count
	localparam logic [7:0] status_offset      = 8'h24;  // Block state (read only)
	localparam logic [7:0] motor_data_offset  = 8'h28;  // Motor data of selected motor

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int run_src_remote_lsb = 0;  // 2 bits
	localparam int run_src_local_lsb  = 2;  // 2 bits
	localparam int dir_allow_lsb      = 4;  // 2 bits
	localparam int local_mode_bit     = 6;
	localparam int set_src_lsb        = 8;  // 2 bits

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] ctrl_reset  = 32'h0000_0031;  // Remote=inputs, local=panel, both dirs
	localparam logic [31:0] param_reset = 32'h0000_0000;  // Default content of a parameter
	localparam logic [31:0] motor_reset = 32'h0000_0000;  // Default motor data
	localparam logic [31:0] unmapped_read = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] { src_panel, src_inputs, src_serial, src_none } cmd_source_type;
	typedef enum logic [1:0] { dir_none, dir_fwd_only, dir_rev_only, dir_both } dir_allow_type;
	typedef enum { st_stopped, st_running, st_jogging, st_braking } motion_state_type;

	// One command word from any source
	typedef struct packed {
		logic stop;
		logic run_forward;
		logic run_reverse;
		logic jog_forward;
		logic jog_reverse;
	} motor_cmd_type;

	// Avalon-MM slave request group
	typedef struct packed {
		logic [7:0]  address;
		logic        read;
		logic        write;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} avalon_req_type;

	// Avalon-MM slave answer group
	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
	} avalon_rsp_type;

	// Motion outputs
	typedef struct packed {
		logic run;
		logic jog;
		logic forward_direction;
		logic reverse_direction;
		logic spin_brake;
	} motion_out_type;

endpackage

// ===== hdl/param_set_store.sv
// Parameter set memory: four sets of parameters behind one port,
// with a sequenced copy and reset walker.
// Assumes sys_clk at 25 MHz and operations started only when idle.
module param_set_store
	import motor_arbiter_pkg::*;
#(
	parameter int depth = 16
)(
	input  wire logic                     sys_clk,
	input  wire logic                     sys_rst,
	input  wire logic [1:0]               edit_set,
	input  wire logic [$clog2(depth)-1:0] edit_index,
	input  wire logic                     edit_write,
	input  wire logic [31:0]              edit_data,
	output logic      [31:0]              edit_q,
	input  wire logic                     op_start,
	input  wire logic                     op_copy,
	input  wire logic [1:0]               op_src,
	input  wire logic [1:0]               op_dst,
	input  wire logic [$clog2(depth)-1:0] op_extent,
	output logic                          op_busy
);
	localparam int iw = $clog2(depth);

	initial
	begin
		if (depth < 2 || depth > 256)
			$error("param_set_store: depth must be 2..256");
	end

	typedef struct packed {
		logic          busy;
		logic          copy;
		logic [1:0]    src;
		logic [1:0]    dst;
		logic [iw-1:0] idx;
		logic [iw-1:0] last;
		logic [31:0]   q;
	} store_state_type;

	store_state_type state_reg;
	store_state_type state_next;
	logic [31:0]     mem [4][depth];

	// ----------------------------------------------------------------
	// Walker sequencing
	// ----------------------------------------------------------------
	always_comb
	begin
		state_next   = state_reg;
		state_next.q = mem[edit_set][edit_index];
		if (!state_reg.busy && op_start)
		begin
			state_next.busy = 1'b1;
			state_next.copy = op_copy;
			state_next.src  = op_src;
			state_next.dst  = op_dst;
			state_next.idx  = '0;
			// Reset extent is selectable; copy always walks the whole set
			state_next.last = op_copy ? iw'(depth - 1) : op_extent;
		end
		else if (state_reg.busy)
		begin
			state_next.idx = state_reg.idx + 1'b1;
			if (state_reg.idx == state_reg.last)
				state_next.busy = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	// Array write port; array kept out of reset so it maps to RAM
	always_ff @(posedge sys_clk)
	begin
		if (state_reg.busy)
			mem[state_reg.dst][state_reg.idx] <= state_reg.copy ?
				mem[state_reg.src][state_reg.idx] : param_reset;
		else if (edit_write)
			mem[edit_set][edit_index] <= edit_data;
	end

	assign edit_q  = state_reg.q;
	assign op_busy = state_reg.busy;
endmodule

// ===== hdl/motor_command_arbiter.sv
// Motor command arbiter: source selection, direction filter, priority
// resolution, parameter set and motor data selection, Avalon-MM registers.
// Assumes all inputs synchronous to sys_clk and a single 25 MHz clock.
// Overview of operation
// - Drop run commands against permitted direction
// - Jog ignored while running normally
// - Start during jog goes to full run
// - Priority: enable, stop, run, jog, spin-brake
// - Inactive enable blocks every start
// - Spin-brake only accepted while stopped
// - Commands from panel, inputs or serial
// - Local/remote toggles source, keeps run state
// - Set selection source is configurable
// - Two set-select inputs pick A to D
// - Set input change acts immediately
// - Set A active after reset, takes edits
// - Any set may activate during operation
// - Global settings held once, not per set
// - Timer count shared, survives set change
// - Copy set duplicates whole set
// - Reset set restores defaults, chosen extent
// - Four motor data sets, first default
// - Unit system change clears motor data
// - Panel memory copy/load only when stopped
// - Local status output high, remote low
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
module motor_command_arbiter
	import motor_arbiter_pkg::*;
#(
	parameter int set_depth = 16
)(
	input  wire logic           sys_clk,
	input  wire logic           sys_rst,
	input  wire avalon_req_type avs_req,
	output avalon_rsp_type      avs_rsp,
	input  wire motor_cmd_type  input_cmd,
	input  wire logic           input_enable,
	input  wire logic           input_spin_brake,
	input  wire logic           input_loc_rem_toggle,
	input  wire logic [1:0]     set_select_in,
	input  wire logic           panel_mem_request,
	output motion_out_type      motion,
	output logic                local_status,
	output logic [1:0]          active_set,
	output logic [1:0]          active_motor,
	output logic                panel_mem_grant
);
	localparam int iw = $clog2(set_depth);

	initial
	begin
		if (set_depth < 2 || set_depth > 256)
			$error("motor_command_arbiter: set_depth must be 2..256");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		motion_state_type mstate;
		logic             dir_fwd;
		logic [31:0]      ctrl;
		motor_cmd_type    panel_cmd;
		motor_cmd_type    serial_cmd;
		logic [1:0]       sw_set;
		logic [1:0]       motor_sel;
		logic             unit_us;
		logic [iw-1:0]    param_addr;
		logic [31:0]      global_word;
		logic [31:0]      timer_count;
		logic             toggle_prev;
		logic             mem_grant;
		logic             op_pulse;
		logic             op_copy;
		logic [1:0]       op_src;
		logic [1:0]       op_dst;
		logic [iw-1:0]    op_extent;
		logic             rd_pending;
		logic [31:0]      readdata;
		logic             ack;
	} arb_state_type;

	arb_state_type state_reg;
	arb_state_type state_next;
	logic [31:0]   motor_data [4];
	logic [31:0]   param_q;
	logic          op_busy;
	logic [1:0]    set_now;
	motor_cmd_type sel_cmd;
	cmd_source_type run_src;
	cmd_source_type set_src;
	dir_allow_type dir_allow;
	logic          run_f_ok;
	logic          run_r_ok;
	logic          jog_f_ok;
	logic          jog_r_ok;
	logic          acc;
	logic          wr_hit;
	logic          rd_hit;
	logic          motor_wr;

	// ----------------------------------------------------------------
	// Source selection and direction filter
	// ----------------------------------------------------------------
	always_comb
	begin
		// Local/remote only picks which configured source is live
		run_src = state_reg.ctrl[local_mode_bit] ?
			cmd_source_type'(state_reg.ctrl[run_src_local_lsb +: 2]) :
			cmd_source_type'(state_reg.ctrl[run_src_remote_lsb +: 2]);
		case (run_src)
			src_panel:  sel_cmd = state_reg.panel_cmd;
			src_inputs: sel_cmd = input_cmd;
			src_serial: sel_cmd = state_reg.serial_cmd;
			default:    sel_cmd = '0;
		endcase
		dir_allow = dir_allow_type'(state_reg.ctrl[dir_allow_lsb +: 2]);
		// Wrong-direction commands vanish with no flag at all
		run_f_ok = sel_cmd.run_forward && (dir_allow == dir_fwd_only || dir_allow == dir_both);
		run_r_ok = sel_cmd.run_reverse && (dir_allow == dir_rev_only || dir_allow == dir_both);
		jog_f_ok = sel_cmd.jog_forward && (dir_allow == dir_fwd_only || dir_allow == dir_both);
		jog_r_ok = sel_cmd.jog_reverse && (dir_allow == dir_rev_only || dir_allow == dir_both);
		set_src  = cmd_source_type'(state_reg.ctrl[set_src_lsb +: 2]);
		// Input selection is combinational so a pin change acts at once
		set_now  = (set_src == src_inputs) ? set_select_in : state_reg.sw_set;
	end

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	assign acc      = (avs_req.read || avs_req.write) && !state_reg.ack;
	assign wr_hit   = acc && avs_req.write;
	assign rd_hit   = acc && avs_req.read;
	assign motor_wr = wr_hit && avs_req.address == motor_data_offset;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		state_next          = state_reg;
		state_next.op_pulse = 1'b0;
		state_next.ack      = 1'b0;
		state_next.timer_count = state_reg.timer_count + 32'h0000_0001;

		// Arbitration, evaluated every cycle; result held in mstate
		if (!input_enable)
			state_next.mstate = st_stopped;
		else if (sel_cmd.stop)
			state_next.mstate = st_stopped;
		else if (run_f_ok || run_r_ok)
		begin
			// Normal start overrides jog and goes to full speed
			state_next.mstate  = st_running;
			state_next.dir_fwd = run_f_ok;
		end
		else if ((jog_f_ok || jog_r_ok) && state_reg.mstate != st_running)
		begin
			state_next.mstate  = st_jogging;
			state_next.dir_fwd = jog_f_ok;
		end
		else if (state_reg.mstate == st_jogging)
			state_next.mstate = st_stopped;  // Jog lasts while held
		else if (input_spin_brake && state_reg.mstate == st_stopped)
			state_next.mstate = st_braking;
		else if (state_reg.mstate == st_braking && !input_spin_brake)
			state_next.mstate = st_stopped;

		// Toggle input flips local/remote on its rising edge only
		state_next.toggle_prev = input_loc_rem_toggle;
		if (input_loc_rem_toggle && !state_reg.toggle_prev)
			state_next.ctrl[local_mode_bit] = !state_reg.ctrl[local_mode_bit];

		// Panel memory transfer only granted from stop
		state_next.mem_grant = panel_mem_request && state_reg.mstate == st_stopped;

		// Bus writes
		if (wr_hit)
		begin
			state_next.ack = 1'b1;
			case (avs_req.address)
				ctrl_offset:       state_next.ctrl = avs_req.writedata;
				panel_cmd_offset:  state_next.panel_cmd = motor_cmd_type'(avs_req.writedata[4:0]);
				serial_cmd_offset: state_next.serial_cmd = motor_cmd_type'(avs_req.writedata[4:0]);
				set_sel_offset:
				begin
					state_next.sw_set    = avs_req.writedata[1:0];
					state_next.motor_sel = avs_req.writedata[5:4];
					state_next.unit_us   = avs_req.writedata[8];
				end
				set_op_offset:
				begin
					state_next.op_pulse  = !op_busy;
					state_next.op_copy   = avs_req.writedata[0];
					state_next.op_src    = avs_req.writedata[5:4];
					state_next.op_dst    = avs_req.writedata[9:8];
					state_next.op_extent = avs_req.writedata[16 +: iw];
				end
				param_addr_offset: state_next.param_addr = avs_req.writedata[iw-1:0];
				global_offset:     state_next.global_word = avs_req.writedata;
				timer_offset:      state_next.timer_count = avs_req.writedata;
				default:           state_next.ack = 1'b1;
			endcase
		end

		// Reads wait one cycle for the parameter memory
		if (rd_hit && !state_reg.rd_pending)
			state_next.rd_pending = 1'b1;
		if (state_reg.rd_pending)
		begin
			state_next.rd_pending = 1'b0;
			state_next.ack        = 1'b1;
			case (avs_req.address)
				ctrl_offset:       state_next.readdata = state_reg.ctrl;
				panel_cmd_offset:  state_next.readdata = {27'h000_0000, state_reg.panel_cmd};
				serial_cmd_offset: state_next.readdata = {27'h000_0000, state_reg.serial_cmd};
				set_sel_offset:    state_next.readdata = {23'h00_0000, state_reg.unit_us, 2'b00,
				                   state_reg.motor_sel, 2'b00, state_reg.sw_set};
				set_op_offset:     state_next.readdata = {31'h0000_0000, op_busy};
				param_addr_offset: state_next.readdata = 32'(state_reg.param_addr);
				param_data_offset: state_next.readdata = param_q;
				global_offset:     state_next.readdata = state_reg.global_word;
				timer_offset:      state_next.readdata = state_reg.timer_count;
				status_offset:     state_next.readdata = {23'h00_0000, state_reg.mem_grant,
				                   set_now, state_reg.ctrl[local_mode_bit], motion};
				motor_data_offset: state_next.readdata = motor_data[state_reg.motor_sel];
				default:           state_next.readdata = unmapped_read;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_reg           <= '0;
			state_reg.mstate    <= st_stopped;
			state_reg.ctrl      <= ctrl_reset;
			state_reg.sw_set    <= 2'b00;
			state_reg.motor_sel <= 2'b00;
		end
		else
			state_reg <= state_next;
	end

	// Motor data held once, outside the sets; unit change clears all
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			motor_data <= '{default: motor_reset};
		else if (wr_hit && avs_req.address == set_sel_offset && avs_req.writedata[8] != state_reg.unit_us)
			motor_data <= '{default: motor_reset};
		else if (motor_wr)
			motor_data[state_reg.motor_sel] <= avs_req.writedata;
	end

	// ----------------------------------------------------------------
	// Parameter sets; edits go to the active set
	// ----------------------------------------------------------------
	param_set_store #(
		.depth (set_depth)
	) u_store (
		.sys_clk    (sys_clk),
		.sys_rst    (sys_rst),
		.edit_set   (set_now),
		.edit_index (state_reg.param_addr),
		.edit_write (wr_hit && avs_req.address == param_data_offset && !op_busy),
		.edit_data  (avs_req.writedata),
		.edit_q     (param_q),
		.op_start   (state_reg.op_pulse),
		.op_copy    (state_reg.op_copy),
		.op_src     (state_reg.op_src),
		.op_dst     (state_reg.op_dst),
		.op_extent  (state_reg.op_extent),
		.op_busy    (op_busy)
	);

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_comb
	begin
		motion.run               = state_reg.mstate == st_running;
		motion.jog               = state_reg.mstate == st_jogging;
		motion.spin_brake        = state_reg.mstate == st_braking;
		motion.forward_direction = (motion.run || motion.jog) && state_reg.dir_fwd;
		motion.reverse_direction = (motion.run || motion.jog) && !state_reg.dir_fwd;
	end

	assign local_status        = state_reg.ctrl[local_mode_bit];
	assign active_set          = set_now;
	assign active_motor        = state_reg.motor_sel;
	assign panel_mem_grant     = state_reg.mem_grant;
	assign avs_rsp.readdata    = state_reg.readdata;
	assign avs_rsp.waitrequest = !state_reg.ack;
endmodule

// ===== verification/motor_arbiter_sva.sv
// Concurrent checks on the motor command arbiter ports.
// Assumes the bench keeps the remote source on the digital inputs.
module motor_arbiter_chk
	import motor_arbiter_pkg::*;
#(
	parameter int set_depth = 16
)(
	input wire logic           sys_clk,
	input wire logic           sys_rst,
	input wire avalon_req_type avs_req,
	input wire avalon_rsp_type avs_rsp,
	input wire motor_cmd_type  input_cmd,
	input wire logic           input_enable,
	input wire logic           input_spin_brake,
	input wire logic           input_loc_rem_toggle,
	input wire logic [1:0]     set_select_in,
	input wire logic           panel_mem_request,
	input wire motion_out_type motion,
	input wire logic           local_status,
	input wire logic [1:0]     active_set,
	input wire logic [1:0]     active_motor,
	input wire logic           panel_mem_grant
);
	// ----------------------------------------------------------------
	// Command arbitration
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// Enable low must stop run and jog on the next edge
	a_enable_blocks_run: assert property (!input_enable |=> !motion.run && !motion.jog)
		else $error("motion while enable low");
	a_stop_beats_run: assert property (input_enable && input_cmd.stop && !local_status |=> !motion.run)
		else $error("run survived a stop");
	a_run_jog_apart: assert property (motion.run |-> !motion.jog)
		else $error("jog and run together");
	a_brake_when_stopped: assert property (motion.spin_brake |-> !motion.run && !motion.jog)
		else $error("brake while operating");
	a_one_direction: assert property (motion.run |-> motion.forward_direction != motion.reverse_direction)
		else $error("run without a single direction");
	// Idle inputs leave a latched run alone
	a_run_held: assert property (motion.run && input_enable && input_cmd == '0 && !local_status |=> motion.run)
		else $error("latched run dropped");
	a_toggle_flips: assert property ($rose(input_loc_rem_toggle) |=> local_status != $past(local_status))
		else $error("local mode did not flip");
	a_grant_stopped: assert property (panel_mem_grant |-> $past(panel_mem_request) && !$past(motion.run))
		else $error("panel memory granted while running");
	// ----------------------------------------------------------------
	// Register bus timing
	// ----------------------------------------------------------------
	a_ack_one_cycle: assert property (!avs_rsp.waitrequest |=> avs_rsp.waitrequest)
		else $error("answer longer than one cycle");
	a_write_answer: assert property ($rose(avs_req.write) |=> !avs_rsp.waitrequest)
		else $error("write answer late");
	a_read_answer: assert property ($rose(avs_req.read) |=> avs_rsp.waitrequest ##1 !avs_rsp.waitrequest)
		else $error("read answer not on second edge");
	c_run: cover property (motion.run);
	c_jog: cover property (motion.jog);
	c_brake: cover property (motion.spin_brake);
	c_grant: cover property (panel_mem_grant);
endmodule

bind motor_command_arbiter motor_arbiter_chk #(.set_depth(set_depth)) chk (
	.sys_clk, .sys_rst, .avs_req, .avs_rsp, .input_cmd, .input_enable, .input_spin_brake,
	.input_loc_rem_toggle, .set_select_in, .panel_mem_request, .motion, .local_status,
	.active_set, .active_motor, .panel_mem_grant
);

// ===== verification/field_input_model.sv
// Model of the field side: digital input levels and panel memory request.
// Assumes the bench calls its tasks one at a time, never in parallel.
module field_input_model
	import motor_arbiter_pkg::*;
(
	input  wire logic     sys_clk,
	output motor_cmd_type input_cmd,
	output logic          input_enable,
	output logic          input_spin_brake,
	output logic          input_loc_rem_toggle,
	output logic [1:0]    set_select_in,
	output logic          panel_mem_request
);
	// Idle at time zero; enable off so nothing starts early
	initial
	begin
		input_cmd = '0;
		input_enable = 1'b0;
		input_spin_brake = 1'b0;
		input_loc_rem_toggle = 1'b0;
		set_select_in = 2'h0;
		panel_mem_request = 1'b0;
	end
	// Levels change after an edge; returns settled two edges later
	task automatic drive(input motor_cmd_type c, input logic en, input logic br, input logic mem);
		@(posedge sys_clk);
		input_cmd <= c;
		input_enable <= en;
		input_spin_brake <= br;
		panel_mem_request <= mem;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	task automatic pick_set(input logic [1:0] s);
		@(posedge sys_clk);
		set_select_in <= s;
	endtask
	// One rising edge per call
	task automatic toggle;
		@(posedge sys_clk);
		input_loc_rem_toggle <= 1'b1;
		@(posedge sys_clk);
		input_loc_rem_toggle <= 1'b0;
	endtask
endmodule

// ===== verification/motor_command_arbiter_tb_top.sv
// Self-checking bench for the motor command arbiter.
// Assumes package, design, field model and checker compiled first.
module motor_command_arbiter_tb_top
	import motor_arbiter_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [4:0] c_idle = 5'h00;
	localparam logic [4:0] c_runf = 5'h08;
	localparam logic [4:0] c_runr = 5'h04;
	localparam logic [4:0] c_jogf = 5'h02;
	localparam logic [4:0] c_stop = 5'h10;
	logic           sys_clk;
	logic           sys_rst;
	avalon_req_type avs_req;
	avalon_rsp_type avs_rsp;
	motor_cmd_type  input_cmd;
	logic           input_enable;
	logic           input_spin_brake;
	logic           input_loc_rem_toggle;
	logic [1:0]     set_select_in;
	logic           panel_mem_request;
	motion_out_type motion;
	logic           local_status;
	logic [1:0]     active_set;
	logic [1:0]     active_motor;
	logic           panel_mem_grant;
	int             error_cnt;
	int             total_checks;
	logic [31:0]    rd;
	logic [31:0]    t1;

	// ----------------------------------------------------------------
	// Clock, design and field model
	// ----------------------------------------------------------------
	initial sys_clk = 1'b0;
	always #20 sys_clk = ~sys_clk;
	motor_command_arbiter dut (.sys_clk, .sys_rst, .avs_req, .avs_rsp, .input_cmd, .input_enable,
		.input_spin_brake, .input_loc_rem_toggle, .set_select_in, .panel_mem_request, .motion,
		.local_status, .active_set, .active_motor, .panel_mem_grant);
	field_input_model fld (.sys_clk, .input_cmd, .input_enable, .input_spin_brake,
		.input_loc_rem_toggle, .set_select_in, .panel_mem_request);

	// ----------------------------------------------------------------
	// Checking and bus tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Outputs are looked at on the falling edge, where they are settled
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int i;
		@(posedge sys_clk);
		avs_req.address <= a;
		avs_req.write <= wr;
		avs_req.read <= !wr;
		avs_req.writedata <= d;
		for (i = 0; i < 20; i++)
		begin
			@(posedge sys_clk);
			if (avs_rsp.waitrequest === 1'b0)
				break;
		end
		error_cnt += (i == 20);
		if (i == 20)
			test_done();
		q = avs_rsp.readdata;
		avs_req.write <= 1'b0;
		avs_req.read <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, rd);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, rd);
		check(rd, exp);
	endtask
	// Copy and reset walk the set for a while; poll busy with a bound
	task automatic wait_idle;
		int i;
		for (i = 0; i < 40; i++)
		begin
			bus(1'b0, set_op_offset, 32'h0, rd);
			if (rd[0] === 1'b0)
				break;
		end
		check(32'(rd[0]), 32'h0);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		error_cnt = 0;
		total_checks = 0;
		sys_rst = 1'b1;
		avs_req = '0;
		avs_req.byteenable = 4'hf;
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		tick(1);
		check(32'(motion), 32'h0);
		check(32'(active_set), 32'h0);
		check(32'(active_motor), 32'h0);
		check(32'(local_status), 32'h0);
		rchk(ctrl_offset, ctrl_reset);
		$display("test reset done");
		fld.drive(c_runf, 1'b1, 1'b0, 1'b0);
		check(32'({motion.run, motion.forward_direction}), 32'h3);
		fld.drive(c_idle, 1'b1, 1'b0, 1'b0);
		check(32'(motion.run), 32'h1);
		fld.drive(c_jogf, 1'b1, 1'b1, 1'b1);
		check(32'({motion.jog, motion.spin_brake, panel_mem_grant}), 32'h0);
		fld.drive(c_stop | c_runf, 1'b1, 1'b0, 1'b1);
		check(32'({motion.run, panel_mem_grant}), 32'h1);
		fld.drive(c_idle, 1'b1, 1'b1, 1'b0);
		check(32'(motion.spin_brake), 32'h1);
		fld.drive(c_jogf, 1'b1, 1'b0, 1'b0);
		check(32'({motion.run, motion.jog}), 32'h1);
		fld.drive(c_jogf | c_runf, 1'b1, 1'b0, 1'b0);
		check(32'({motion.run, motion.jog}), 32'h2);
		fld.drive(c_runf, 1'b0, 1'b0, 1'b0);
		check(32'(motion.run), 32'h0);
		$display("test commands done");
		wr(ctrl_offset, 32'h0000_0011);
		fld.drive(c_runr, 1'b1, 1'b0, 1'b0);
		check(32'(motion.run), 32'h0);
		fld.drive(c_runf, 1'b1, 1'b0, 1'b0);
		check(32'(motion.run), 32'h1);
		wr(ctrl_offset, ctrl_reset);
		fld.drive(c_idle, 1'b1, 1'b0, 1'b0);
		fld.toggle();
		tick(2);
		check(32'({local_status, motion.run}), 32'h3);
		wr(panel_cmd_offset, 32'h0000_0010);
		tick(2);
		check(32'(motion.run), 32'h0);
		wr(panel_cmd_offset, 32'h0000_0008);
		tick(2);
		check(32'(motion.run), 32'h1);
		wr(panel_cmd_offset, 32'h0000_0000);
		fld.toggle();
		tick(2);
		check(32'({local_status, motion.run}), 32'h1);
		$display("test sources done");
		// Set inputs take over while the motor keeps running
		wr(ctrl_offset, 32'h0000_0131);
		for (int s = 0; s < 4; s++)
		begin
			fld.pick_set(2'(s));
			tick(1);
			check(32'(active_set), 32'(s));
		end
		fld.drive(c_stop, 1'b1, 1'b0, 1'b0);
		wr(ctrl_offset, ctrl_reset);
		wr(set_sel_offset, 32'h0000_0000);
		wr(param_addr_offset, 32'h0000_0002);
		wr(param_data_offset, 32'h1234_5678);
		wr(global_offset, 32'h0000_00a5);
		wr(set_op_offset, 32'h0000_0101);
		wait_idle();
		bus(1'b0, timer_offset, 32'h0, t1);
		wr(set_sel_offset, 32'h0000_0001);
		tick(1);
		check(32'(active_set), 32'h1);
		rchk(param_data_offset, 32'h1234_5678);
		rchk(global_offset, 32'h0000_00a5);
		bus(1'b0, timer_offset, 32'h0, rd);
		check(32'(rd > t1), 32'h1);
		wr(set_op_offset, 32'h000f_0100);
		wait_idle();
		rchk(param_data_offset, param_reset);
		wr(set_sel_offset, 32'h0000_0000);
		rchk(param_data_offset, 32'h1234_5678);
		$display("test sets done");
		wr(set_sel_offset, 32'h0000_0010);
		tick(1);
		check(32'(active_motor), 32'h1);
		wr(motor_data_offset, 32'h0000_abcd);
		rchk(motor_data_offset, 32'h0000_abcd);
		wr(set_sel_offset, 32'h0000_0110);
		rchk(motor_data_offset, motor_reset);
		rchk(8'hfc, unmapped_read);
		$display("test motor data done");
		test_done();
	end
endmodule
